// ---- verilog/sync_serial_full_duplex.sv ----
// The placing of the registers and the plain strobed port were chosen for this implementation.
`default_nettype none
// How it works
// - mode code 10 selects full-duplex operation
// - tx write clears empty; rx read clears full
// - running flag rises at next serial fall
// - send on falling edge, sample on rising
// - shifting flag spans first to eighth fall
// - empty flag sets at rise after load
// - eighth bit copies buffer, sets full, interrupts
// - internal clock starts within one serial period
// - external clock loads on first incoming fall
// - internal clock halts high until both accesses
// - write plus read resumes within one period
// - start with empty buffer raises tx error
// - unread buffer at frame end raises rx error
// - run cleared: finish frame, stop, output high
// - force stop aborts and resets flags, buffers, shift registers and run
// - tx error holds output high, interrupt after eight
// - rx error freezes buffer and shift register
// - error reads: good frame, then shift register
// - run cleared after rx error ends frame
module sync_serial_full_duplex #(
  parameter int unsigned SCK_HALF = sio_pkg::SCK_HALF_DEF
) (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     clk_en,
  input  wire logic [sio_pkg::AW-1:0]   addr,
  input  wire logic [sio_pkg::DW-1:0]   wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output var  logic [sio_pkg::DW-1:0]   rdata,
  input  wire logic                     sck_in,
  output var  logic                     sck_out,
  output var  logic                     sck_oe,
  input  wire logic                     si_pin,
  output var  logic                     serial_out_pin,
  output var  logic                     transfer_interrupt
);
  import sio_pkg::*;

  // ***************************************************
  // helpers
  // ***************************************************
  // one step of the shift register in the chosen bit order
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b, input logic msb);
    shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction

  // bit that leaves the register next
  function automatic logic out_bit(input logic [7:0] v, input logic msb);
    out_bit = msb ? v[7] : v[0];
  endfunction

  // ***************************************************
  // state
  // ***************************************************
  logic [1:0] mode_ff;
  logic       order_ff;
  logic       ext_ff;
  logic       run_ff;
  logic       running_ff;
  logic       sef_ff;
  logic       txe_ff;
  logic       rxf_ff;
  logic       tx_error_flag_ff;
  logic       rx_error_flag_ff;
  logic [7:0] txb_ff;
  logic [7:0] rxb_ff;
  logic [7:0] tsh_ff;
  logic [7:0] rsh_ff;
  logic       active_ff;
  logic [2:0] fcnt_ff;
  logic [2:0] rcnt_ff;
  logic       wseen_ff;
  logic       rseen_ff;
  logic       errrd_ff;
  logic [7:0] div_ff;
  logic       sck_int_ff;
  logic       sck_oe_ff;
  logic       s1_ff;
  logic       s2_ff;
  logic       s3_ff;
  logic       si1_ff;
  logic       si2_ff;
  logic       so_ff;
  logic       irq_ff;
  logic [7:0] rdata_ff;

  // ***************************************************
  // register decode
  // ***************************************************
  logic wr_ctl;
  logic wr_st;
  logic wr_tx;
  logic rd_rx;
  logic fstop;
  logic err_clr;
  assign wr_ctl  = wr && (addr == ADDR_CTRL);
  assign wr_st   = wr && (addr == ADDR_STAT);
  assign wr_tx   = wr && (addr == ADDR_TXB);
  assign rd_rx   = rd && (addr == ADDR_RXB);
  assign fstop   = wr_ctl && wdata[CTL_STOP];
  // writing zero to the rx error bit acknowledges it
  assign err_clr = wr_st && !wdata[ST_RX_ERROR_FLAG] && rx_error_flag_ff;

  // ***************************************************
  // serial clock edges
  // ***************************************************
  logic mode_ok;
  logic start_ok;
  logic int_go;
  logic tick;
  logic fall_ev;
  logic rise_ev;
  assign mode_ok = (mode_ff == MODE_TXRX);
  // internal clock waits for both accesses; external never waits
  assign start_ok = mode_ok && run_ff && !active_ff
                    && (ext_ff || (wseen_ff && rseen_ff));
  assign int_go  = !ext_ff && (active_ff || start_ok);
  assign tick    = (div_ff == 8'(SCK_HALF - 1));
  assign fall_ev = ext_ff ? (s3_ff && !s2_ff) : (int_go && tick && sck_int_ff);
  assign rise_ev = ext_ff ? (!s3_ff && s2_ff) : (int_go && tick && !sck_int_ff);

  // ***************************************************
  // frame events
  // ***************************************************
  logic       start;
  logic       fbit;
  logic       rbit;
  logic       done;
  logic       tx_miss;
  logic       rx_ovr;
  logic       rx_take;
  logic       txe_set;
  logic [7:0] rsh_nx;
  assign start   = fall_ev && start_ok;
  assign fbit    = fall_ev && active_ff;
  assign rbit    = rise_ev && active_ff;
  assign done    = rbit && (rcnt_ff == LAST_BIT);
  assign tx_miss = txe_ff && !wseen_ff;
  // a read in the very cycle of the last bit is still in time
  assign rx_ovr  = done && rxf_ff && !rd_rx && !rx_error_flag_ff;
  assign rx_take = done && !rx_error_flag_ff && !rx_ovr;
  assign txe_set = rbit && (rcnt_ff == 3'h0);
  assign rsh_nx  = shift_in(rsh_ff, si2_ff, order_ff);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_ff  <= 1'b1;
      s2_ff  <= 1'b1;
      s3_ff  <= 1'b1;
      si1_ff <= 1'b0;
      si2_ff <= 1'b0;
    end else if (clk_en) begin
      s1_ff  <= sck_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;  // edge detect looks at s2/s3 only
      si1_ff <= si_pin;
      si2_ff <= si1_ff;
    end
  end

  // ***************************************************
  // control register
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_ff  <= 2'h0;
      order_ff <= 1'b0;
      ext_ff   <= 1'b0;
      run_ff   <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      mode_ff  <= wdata[CTL_MODE +: 2];
      order_ff <= wdata[CTL_ORDER];
      ext_ff   <= wdata[CTL_CLKSRC];
      run_ff   <= wdata[CTL_RUN] && !fstop;
    end
  end

  // ***************************************************
  // internal clock divider
  // ***************************************************
  // counter restarts on every wait, so a resume costs under a period
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_ff     <= 8'h00;
      sck_int_ff <= 1'b1;
      sck_oe_ff  <= 1'b0;
    end else if (clk_en) begin
      div_ff     <= (!int_go || tick) ? 8'h00 : div_ff + 8'h01;
      sck_oe_ff  <= !ext_ff && mode_ok;
      if (fstop || ext_ff) begin
        sck_int_ff <= 1'b1;
      end else if (int_go && tick) begin
        sck_int_ff <= !sck_int_ff;
      end
    end
  end

  // ***************************************************
  // frame sequencing
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      active_ff <= 1'b0;
      fcnt_ff   <= 3'h0;
      rcnt_ff   <= 3'h0;
      sef_ff    <= 1'b0;
    end else if (clk_en) begin
      if (fstop) begin
        active_ff <= 1'b0;
        sef_ff    <= 1'b0;
      end else if (start) begin
        active_ff <= 1'b1;
        fcnt_ff   <= 3'h1;
        rcnt_ff   <= 3'h0;
        sef_ff    <= 1'b1;
      end else begin
        if (done) begin
          active_ff <= 1'b0;
        end
        if (fbit) begin
          fcnt_ff <= fcnt_ff + 3'h1;
        end
        if (fbit && fcnt_ff == LAST_BIT) begin
          sef_ff <= 1'b0;
        end
        if (rbit) begin
          rcnt_ff <= rcnt_ff + 3'h1;
        end
      end
    end
  end

  // running flag follows run_request only at frame boundaries
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      running_ff <= 1'b0;
    end else if (clk_en) begin
      if (fstop) begin
        running_ff <= 1'b0;
      end else if (start) begin
        running_ff <= 1'b1;
      end else if (!run_ff && (!active_ff || done)) begin
        running_ff <= 1'b0;
      end
    end
  end

  // ***************************************************
  // transmit path
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      txb_ff <= BYTE_RST;
      tsh_ff <= BYTE_RST;
    end else if (clk_en) begin
      if (fstop) begin
        txb_ff <= BYTE_RST;
        tsh_ff <= BYTE_RST;
      end else begin
        if (wr_tx) begin
          txb_ff <= wdata;
        end
        if (start) begin
          tsh_ff <= shift_in(txb_ff, 1'b1, order_ff);
        end else if (fbit) begin
          tsh_ff <= shift_in(tsh_ff, 1'b1, order_ff);
        end
      end
    end
  end

  // output is high from reset and idles high once run is cleared, and stays high through a tx error;
  // after a stop it goes high a cycle past the last rise, so the peer still gets bit eight
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      so_ff <= 1'b1;
    end else if (clk_en) begin
      if (fstop || tx_error_flag_ff || (start && tx_miss)) begin
        so_ff <= 1'b1;
      end else if (start) begin
        so_ff <= out_bit(txb_ff, order_ff);
      end else if (fbit && fcnt_ff != 3'h0) begin
        so_ff <= out_bit(tsh_ff, order_ff);
      end else if (!active_ff && !run_ff) begin
        so_ff <= 1'b1;
      end
    end
  end

  // ***************************************************
  // receive path
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rsh_ff <= BYTE_RST;
      rxb_ff <= BYTE_RST;
    end else if (clk_en) begin
      if (fstop) begin
        rsh_ff <= BYTE_RST;
        rxb_ff <= BYTE_RST;
      end else begin
        if (rbit && !rx_error_flag_ff) begin
          rsh_ff <= rsh_nx;
        end
        if (rx_take) begin
          rxb_ff <= rsh_nx;
        end
      end
    end
  end

  // ***************************************************
  // status flags; a hardware set beats a software clear
  // ***************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      txe_ff   <= TXE_RST;
      rxf_ff   <= 1'b0;
      tx_error_flag_ff <= 1'b0;
      rx_error_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (fstop) begin
        txe_ff   <= TXE_RST;
        rxf_ff   <= 1'b0;
        tx_error_flag_ff <= 1'b0;
        rx_error_flag_ff <= 1'b0;
      end else begin
        if (txe_set) begin
          txe_ff <= 1'b1;
        end else if (wr_tx) begin
          txe_ff <= 1'b0;
        end
        if (rx_take) begin
          rxf_ff <= 1'b1;
        end else if (rd_rx || err_clr) begin
          rxf_ff <= 1'b0;
        end
        if (start && tx_miss) begin
          tx_error_flag_ff <= 1'b1;
        end
        if (rx_ovr) begin
          rx_error_flag_ff <= 1'b1;
        end else if (err_clr) begin
          rx_error_flag_ff <= 1'b0;
        end
      end
    end
  end

  // access tracking for the automatic wait and error reads
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wseen_ff <= 1'b0;
      rseen_ff <= 1'b1;
      errrd_ff <= 1'b0;
    end else if (clk_en) begin
      if (fstop) begin
        wseen_ff <= 1'b0;
        rseen_ff <= 1'b1;
      end else begin
        // an access in the start cycle counts for the next frame
        wseen_ff <= wr_tx || (wseen_ff && !start);
        rseen_ff <= rd_rx || (rseen_ff && !start);
      end
      if (fstop || !rx_error_flag_ff) begin
        errrd_ff <= 1'b0;
      end else if (rd_rx) begin
        errrd_ff <= 1'b1;
      end
    end
  end

  // interrupt waits for the full eighth bit even on a tx error
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= done && !rx_error_flag_ff && !fstop;
    end
  end

  // ***************************************************
  // read mux
  // ***************************************************
  logic [7:0] ctl_rd;
  logic [7:0] st_rd;
  logic [7:0] rd_mux;
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[CTL_MODE +: 2] = mode_ff;
    ctl_rd[CTL_ORDER]     = order_ff;
    ctl_rd[CTL_CLKSRC]    = ext_ff;
    ctl_rd[CTL_RUN]       = run_ff;
    st_rd = 8'h00;
    st_rd[ST_RUN]   = running_ff;
    st_rd[ST_SHIFT] = sef_ff;
    st_rd[ST_TXE]   = txe_ff;
    st_rd[ST_RXF]   = rxf_ff;
    st_rd[ST_TX_ERROR_FLAG] = tx_error_flag_ff;
    st_rd[ST_RX_ERROR_FLAG] = rx_error_flag_ff;
  end
  // second read after an rx error shows the frozen shift register
  assign rd_mux = (addr == ADDR_CTRL) ? ctl_rd
                : (addr == ADDR_STAT) ? st_rd
                : (addr == ADDR_TXB)  ? txb_ff
                : (addr == ADDR_RXB)  ? ((rx_error_flag_ff && errrd_ff) ? rsh_ff : rxb_ff)
                : 8'h00;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      rdata_ff <= rd ? rd_mux : 8'h00;
    end
  end

  assign rdata              = rdata_ff;
  assign sck_out            = sck_int_ff;
  assign sck_oe             = sck_oe_ff;
  assign serial_out_pin     = so_ff;
  assign transfer_interrupt = irq_ff;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_txe_wr_clear: assert property (
    (clk_en && wr_tx && !txe_set && !fstop) |=> !txe_ff)
    else $error("tx empty flag not cleared by write");
  chk_rxf_rd_clear: assert property (
    (clk_en && rd_rx && !rx_take) |=> !rxf_ff)
    else $error("rx full flag not cleared by read");
  chk_run_on_fall: assert property (
    $rose(running_ff) |-> $past(fall_ev))
    else $error("running flag rose off a falling edge");
  chk_sef_on_fall: assert property (
    $rose(sef_ff) |-> $past(fall_ev) && $past(start))
    else $error("shifting flag rose without frame start");
  chk_irq_with_full: assert property (
    irq_ff |-> rxf_ff && !active_ff)
    else $error("interrupt without full buffer");
  chk_wait_high: assert property (
    (!ext_ff && !active_ff && !start_ok)[*2] |-> sck_int_ff && !fall_ev)
    else $error("internal clock not halted high");
  chk_tx_error_flag_set: assert property (
    (clk_en && start && tx_miss && !fstop) |=> tx_error_flag_ff && so_ff)
    else $error("tx error not raised at start");
  chk_stop_frame: assert property (
    (clk_en && done && !run_ff && !fstop) |=> !running_ff ##1 so_ff)
    else $error("stop did not end cleanly");
  chk_tx_error_flag_so_high: assert property (
    (clk_en && tx_error_flag_ff) |=> so_ff)
    else $error("output not high on tx error");
  chk_rx_error_flag_frozen: assert property (
    (clk_en && rx_error_flag_ff && !fstop) |=> $stable(rxb_ff) && $stable(rsh_ff))
    else $error("data changed during rx error");

  cov_good_frame: cover property (clk_en && rx_take);
  cov_tx_error:   cover property (clk_en && start && tx_miss);
  cov_rx_error:   cover property (clk_en && rx_ovr);
endmodule
`default_nettype wire

// ---- verilog/sio_pkg.sv ----
`default_nettype none
package sio_pkg;
  // ***************************************************
  // bus geometry and register offsets
  // ***************************************************
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT = 4'h4;
  localparam logic [AW-1:0] ADDR_TXB  = 4'h8;
  localparam logic [AW-1:0] ADDR_RXB  = 4'hc;

  // ***************************************************
  // control_reg fields
  // ***************************************************
  localparam int unsigned CTL_MODE   = 0;  // two bits
  localparam int unsigned CTL_ORDER  = 2;  // 1: msb first
  localparam int unsigned CTL_CLKSRC = 3;  // 1: external clock
  localparam int unsigned CTL_RUN    = 4;
  localparam int unsigned CTL_STOP   = 5;  // write one, reads zero
  localparam logic [1:0] MODE_TXRX   = 2'h2;

  // ***************************************************
  // status_reg fields and reset values
  // ***************************************************
  localparam int unsigned ST_RUN   = 0;
  localparam int unsigned ST_SHIFT = 1;
  localparam int unsigned ST_TXE   = 2;
  localparam int unsigned ST_RXF   = 3;
  localparam int unsigned ST_TX_ERROR_FLAG = 4;
  localparam int unsigned ST_RX_ERROR_FLAG = 5;
  localparam logic TXE_RST         = 1'h1;
  localparam logic [DW-1:0] BYTE_RST = 8'h00;

  // ***************************************************
  // frame and serial clock timing
  // ***************************************************
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int unsigned SCK_HALF_DEF = 4;  // mclk cycles per half period
endpackage
`default_nettype wire

// ---- dv/serial_peer.sv ----
`default_nettype none
// ***************************************************
// far-side serial peer: clocks in external mode, shifts always
// ***************************************************
module serial_peer (
  input  wire logic       sck_line,
  input  wire logic       so_pin,
  input  wire logic       ext_go,
  input  wire logic       msb,
  input  wire logic [7:0] tx_byte,
  output var  logic       peer_sck,
  output var  logic       si,
  output var  logic [7:0] rx_byte,
  output var  logic [7:0] starts,
  output var  logic [7:0] done
);
  timeunit 1ns;
  timeprecision 1ns;
  int         nf;
  int         nr;
  logic [7:0] rxv;

  // idle line stands high, data idles high
  initial begin
    peer_sck = 1'b1;
    si = 1'b1;
    nf = 0;
    nr = 0;
    starts = 8'h00;
    done = 8'h00;
    rx_byte = 8'h00;
  end

  // eight clocks per frame only; odd offset keeps phase unrelated to mclk
  always @(posedge ext_go) begin
    #7;
    repeat (8) begin
      #200 peer_sck = 1'b0;
      #200 peer_sck = 1'b1;
    end
  end

  // peer launches its bits on the falling edge
  always @(negedge sck_line) begin
    if (nf == 0) starts = starts + 8'h01;
    si = msb ? tx_byte[7 - nf] : tx_byte[nf];
    nf = nf + 1;
  end

  // peer samples on the rising edge; data flips once hold has run out
  always @(posedge sck_line) begin
    if (nf != 0) begin
      rxv = msb ? {rxv[6:0], so_pin} : {so_pin, rxv[7:1]};
      nr = nr + 1;
      if (nr == 8) begin
        nf = 0;
        nr = 0;
        rx_byte = rxv;
        done = done + 8'h01;
        #100 si = ~si;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
// ***************************************************
// top-level bench: register tasks and frame scenarios
// ***************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sio_pkg::*;
  logic          mclk;
  logic          rstn;
  logic          clk_en;
  logic          wr;
  logic          rd;
  logic          ext_go;
  logic          msb;
  logic          si;
  logic          sck_out;
  logic          sck_oe;
  logic          sck_line;
  logic          peer_sck;
  logic          so;
  logic          intr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic [7:0]    ptx;
  logic [7:0]    prx;
  logic [7:0]    starts;
  logic [7:0]    done;
  logic [7:0]    got;
  int            fails;
  int            checks;
  int            nint;

  // clock, resolved serial clock wire, interrupt pulse count
  always #25 mclk = ~mclk;
  assign sck_line = sck_oe ? sck_out : peer_sck;
  always @(posedge mclk) if (intr === 1'b1) nint++;

  sync_serial_full_duplex #(.SCK_HALF(4)) DUT (
    .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe(sck_oe), .si_pin(si), .serial_out_pin(so), .transfer_interrupt(intr)
  );

  serial_peer peer (
    .sck_line(sck_line), .so_pin(so), .ext_go(ext_go), .msb(msb), .tx_byte(ptx),
    .peer_sck(peer_sck), .si(si), .rx_byte(prx), .starts(starts), .done(done)
  );

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic wreg(input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [AW-1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [7:0] e, input string m);
    rreg(a);
    check(got, e, m);
  endtask

  task automatic pulse;
    @(posedge mclk);
    ext_go <= 1'b1;
    @(posedge mclk);
    ext_go <= 1'b0;
  endtask

  // bounded wait on the peer's start or done count
  task automatic wait_cnt(input bit st, input logic [7:0] n);
    for (int i = 0; i < 80 && (st ? starts : done) !== n; i++) @(posedge mclk);
    check(st ? starts : done, n, "frame count");
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    #400000;
    fails++;
    $display("unexpected at %0t: watchdog", $time);
    conclude();
  end

  // ***************************************************
  // scenarios
  // ***************************************************
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    ext_go = 1'b0;
    msb = 1'b1;
    addr = '0;
    wdata = '0;
    ptx = 8'h00;
    fails = 0;
    checks = 0;
    nint = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    check({7'h00, so}, 8'h01, "idle out");
    rchk(ADDR_STAT, 8'h04, "reset status");
    rchk(ADDR_CTRL, 8'h00, "reset ctrl");
    rchk(4'h2, 8'h00, "unmapped");
    // internal clock, msb first, then auto-wait and resume
    wreg(ADDR_TXB, 8'h3c);
    rchk(ADDR_STAT, 8'h00, "tx empty cleared");
    ptx <= 8'ha5;
    wreg(ADDR_CTRL, 8'h16);
    wait_cnt(1'b0, 8'h01);
    check(prx, 8'h3c, "peer rx msb");
    check(nint[7:0], 8'h01, "interrupt");
    rchk(ADDR_STAT, 8'h0d, "after frame");
    rchk(ADDR_RXB, 8'ha5, "rx msb");
    rchk(ADDR_STAT, 8'h05, "rx full cleared");
    repeat (40) @(posedge mclk);
    check(starts, 8'h01, "halted");
    check({7'h00, sck_out}, 8'h01, "clock high");
    check({7'h00, sck_oe}, 8'h01, "clock driven");
    ptx <= 8'h5a;
    wreg(ADDR_TXB, 8'hc3);
    wait_cnt(1'b0, 8'h02);
    check(prx, 8'hc3, "resumed");
    // lsb first with a graceful stop mid-frame
    rchk(ADDR_RXB, 8'h5a, "rx second");
    msb <= 1'b0;
    ptx <= 8'h1e;
    wreg(ADDR_CTRL, 8'h12);
    wreg(ADDR_TXB, 8'h2d);
    wait_cnt(1'b1, 8'h03);
    rreg(ADDR_STAT);
    check(got & 8'h03, 8'h03, "running shifting");
    wreg(ADDR_CTRL, 8'h02);
    wait_cnt(1'b0, 8'h03);
    check(prx, 8'h2d, "peer rx lsb");
    rchk(ADDR_RXB, 8'h1e, "rx lsb");
    rchk(ADDR_STAT, 8'h04, "stopped");
    check({7'h00, so}, 8'h01, "out high");
    // external clock, good frame then a transmit error
    msb <= 1'b1;
    ptx <= 8'h69;
    wreg(ADDR_CTRL, 8'h1e);
    wreg(ADDR_TXB, 8'h96);
    pulse();
    wait_cnt(1'b0, 8'h04);
    check(prx, 8'h96, "ext tx");
    check({7'h00, sck_oe}, 8'h00, "clock released");
    rchk(ADDR_RXB, 8'h69, "ext rx");
    ptx <= 8'h0f;
    pulse();
    wait_cnt(1'b0, 8'h05);
    check(prx, 8'hff, "out held high");
    check(nint[7:0], 8'h05, "deferred interrupt");
    rchk(ADDR_STAT, 8'h1d, "tx error");
    rchk(ADDR_RXB, 8'h0f, "rx before abort");
    wreg(ADDR_CTRL, 8'h20);
    rchk(ADDR_STAT, 8'h04, "forced status");
    rchk(ADDR_CTRL, 8'h00, "forced ctrl");
    rchk(ADDR_RXB, 8'h00, "forced rx");
    // external clock receive overrun and recovery
    wreg(ADDR_CTRL, 8'h1e);
    wreg(ADDR_TXB, 8'h11);
    ptx <= 8'h44;
    pulse();
    wait_cnt(1'b0, 8'h06);
    wreg(ADDR_TXB, 8'h22);
    ptx <= 8'h55;
    pulse();
    wait_cnt(1'b0, 8'h07);
    check(nint[7:0], 8'h07, "overrun interrupt");
    rchk(ADDR_STAT, 8'h2d, "rx error");
    wreg(ADDR_CTRL, 8'h0e);
    ptx <= 8'h77;
    pulse();
    wait_cnt(1'b0, 8'h08);
    check(nint[7:0], 8'h07, "discarded");
    rreg(ADDR_STAT);
    check(got & 8'h01, 8'h00, "stopped after error");
    rchk(ADDR_RXB, 8'h44, "last good");
    rchk(ADDR_RXB, 8'h55, "shift contents");
    wreg(ADDR_STAT, 8'h00);
    rreg(ADDR_STAT);
    check(got & 8'h28, 8'h00, "error cleared");
    conclude();
  end
endmodule
`default_nettype wire
